// [sim/eibm_cipher_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the block cipher: a keystream chosen by block number
module eibm_cipher_model
(
  input wire logic [3:0] i_block,
  output logic [127:0] o_keystream
);
  // Halves differ so that a swapped half shows up in the output
  assign o_keystream = {{16{i_block}}, {16{~i_block}}};
endmodule // eibm_cipher_model
`default_nettype wire

// [sim/eibm_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module eibm_top_tb;
  // One row: word kind, word, block number, repeat count, expected output
  typedef struct packed {
    logic [2:0] kind;
    logic [71:0] word;
    logic [3:0] blk;
    logic [5:0] rep;
    logic [71:0] exp;
  } eibm_row_s;
  localparam logic [47:0] T0 = 48'h0000_1234_5678;
  localparam logic [47:0] OFS = 48'h0000_0000_0010;
  localparam logic [47:0] TBL = 48'h0a0b_0c0d_0e0f;
  localparam logic [47:0] LRN = 48'h0c00_0000_0077;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] role = 2'b00;
  logic tick = 1'b0;
  logic tload = 1'b0;
  logic [47:0] tval = 48'h0;
  logic twr = 1'b0;
  logic wvalid = 1'b0;
  logic [2:0] wkind = 3'h0;
  logic [71:0] wdata = 72'h0;
  logic [7:0] wch = 8'h0;
  logic [3:0] llid = 4'h0;
  logic [3:0] blk = 4'h0;
  logic [127:0] ks;
  logic [127:0] vec;
  logic vec_valid;
  logic ow_valid;
  logic [71:0] ow;
  logic [31:0] lcount;
  logic [47:0] ctimer;
  logic [31:0] lc0;
  logic [47:0] st;
  eibm_row_s rows [7];
  int error_cnt = 0;
  int samples_checked = 0;
  always #20 core_clk = ~core_clk;
  eibm_cipher_model i_eibm_cipher_model (.i_block(blk), .o_keystream(ks));
  eibm_top i_eibm_top (.i_core_clk(core_clk), .i_resetn(resetn), .i_role(role),
    .i_quantum_tick(tick), .i_timer_load(tload), .i_timer_load_value(tval),
    .i_rx_offset(OFS), .i_learned_station(LRN), .i_table_wr(twr),
    .i_table_wr_llid(4'h5), .i_table_wr_addr(TBL), .i_word_valid(wvalid),
    .i_word_kind(wkind), .i_word(wdata), .i_word_channel(wch), .i_header_llid(llid),
    .i_header_align(T0[5:0] + 6'h3), .i_header_last(1'b0), .i_keystream(ks),
    .o_vector(vec), .o_vector_valid(vec_valid), .o_word_valid(ow_valid), .o_word(ow),
    .o_local_count(lcount), .o_cipher_timer(ctimer));
  // Bench's own keystream and masking, kept apart from the design
  function automatic logic [127:0] kst(input logic [3:0] b);
    return {{16{b}}, {16{~b}}};
  endfunction
  // Upper keystream half for the first word of a block, lower for the second
  function automatic logic [71:0] enc(input logic [71:0] w, input logic [3:0] b,
                                      input logic hi);
    logic [63:0] m;
    logic [127:0] k;
    k = kst(b);
    for (int i = 0; i < 8; i++)
      m[8*i+:8] = w[64+i] ? eibm_pkg::MASK_CTRL : eibm_pkg::MASK_DATA;
    return {w[71:64], w[63:0] ^ ((hi ? k[127:64] : k[63:0]) & m)};
  endfunction
  task automatic chk_word(input logic [71:0] got, input logic [71:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t word got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_vec(input logic [127:0] got, input logic [127:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t value got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t count got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One word in, held for one edge; output settled 1 ns after the next
  task automatic send(input logic [2:0] k, input logic [71:0] w, input logic [3:0] b);
    @(posedge core_clk);
    wvalid <= 1'b1;
    wkind <= k;
    wdata <= w;
    blk <= b;
    @(posedge core_clk);
    wvalid <= 1'b0;
    #1;
  endtask
  task automatic end_sim();
    $display("Counts: %0d checked, %0d mismatched", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    rows[0] = {3'h1, 72'hff_0000_0000_0000_00fb, 4'h0, 6'h1, 72'hff_0000_0000_0000_00fb};
    rows[1] = {3'h0, 72'h00_0123_4567_89ab_cdef, 4'h0, 6'h1, 72'h0};
    rows[2] = {3'h2, 72'hff_1c1c_1c1c_1c1c_1c1c, 4'h0, 6'd33, 72'hff_1c1c_1c1c_1c1c_1c1c};
    rows[3] = {3'h0, 72'h0f_1122_3344_0707_07fd, 4'h0, 6'h1, 72'h0};
    rows[4] = {3'h0, 72'h00_fedc_ba98_7654_3210, 4'h1, 6'h1, 72'h0};
    rows[5] = {3'h3, 72'hff_0707_0707_0707_0707, 4'h1, 6'h1, 72'hff_0707_0707_0707_0707};
    rows[6] = {3'h4, 72'hff_0707_0707_0707_0707, 4'h1, 6'h1, 72'hff_0707_0707_0707_0707};
    rows[1].exp = enc(rows[1].word, 4'h0, 1'b1);
    rows[3].exp = enc(rows[3].word, 4'h0, 1'b0);
    rows[4].exp = enc(rows[4].word, 4'h1, 1'b1);
    // Reset held for 16 cycles, outputs checked inside it
    repeat (16) @(posedge core_clk);
    chk_vec({ow_valid, vec_valid, ow, vec[53:0]}, 128'h0);
    chk_vec({48'h0, ctimer, lcount}, 128'h0);
    resetn <= 1'b1;
    $display("Test reset done");
    // Load the timer, then three quanta
    @(posedge core_clk);
    tload <= 1'b1;
    tval <= T0;
    twr <= 1'b1;
    @(posedge core_clk);
    tload <= 1'b0;
    twr <= 1'b0;
    @(posedge core_clk);
    #1;
    chk_cnt(ctimer, T0);
    lc0 = lcount;
    @(posedge core_clk);
    tick <= 1'b1;
    repeat (3) @(posedge core_clk);
    tick <= 1'b0;
    @(posedge core_clk);
    #1;
    chk_cnt(ctimer, T0 + 48'h3);
    chk_cnt({16'h0, lcount}, {16'h0, lc0 + 32'h3});
    $display("Test timers done");
    // Envelope with a pacing run in mid-block and an odd tail
    wch <= 8'h02;
    for (int r = 0; r < 7; r++)
    begin
      for (int n = 0; n < rows[r].rep; n++)
      begin
        send(rows[r].kind, rows[r].word, rows[r].blk);
        chk_word(ow, rows[r].exp);
        chk_cnt({47'h0, ow_valid}, 48'h1);
      end
    end
    $display("Test envelope rows done");
    // Header in every role: channel, address source, timer source
    for (int r = 0; r < 4; r++)
    begin
      @(posedge core_clk);
      role <= r[1:0];
      wch <= 8'h10 + r[7:0];
      llid <= 4'h5;
      send(3'h1, 72'hff_0000_0000_0000_00fb, 4'h0);
      st = (r == 1) ? TBL : (r == 3) ? LRN : eibm_pkg::OWN_STATION_ADDR;
      chk_cnt({47'h0, vec_valid}, 48'h1);
      chk_vec(vec, {8'h10 + r[7:0], st, T0 + 48'h3 - ((r == 3) ? OFS : 48'h0), 24'h0});
    end
    $display("Test vector roles done");
    // Unit receive: decrypt two words, block restarts after header
    send(3'h0, rows[1].word, 4'h0);
    chk_word(ow, enc(rows[1].word, 4'h0, 1'b1));
    send(3'h0, rows[4].word, 4'h0);
    chk_word(ow, enc(rows[4].word, 4'h0, 1'b0));
    // Idle word inside a payload gets an all-zero mask
    send(3'h0, 72'hff_0707_0707_0707_0707, 4'h1);
    chk_word(ow, 72'hff_0707_0707_0707_0707);
    $display("Test receive block done");
    // Reset in mid-run: outputs clear, then a payload outside any envelope passes
    @(posedge core_clk);
    resetn <= 1'b0;
    @(posedge core_clk);
    #1;
    chk_vec({ow_valid, vec_valid, ow, vec[53:0]}, 128'h0);
    chk_vec({48'h0, ctimer, lcount}, 128'h0);
    @(posedge core_clk);
    resetn <= 1'b1;
    send(3'h0, rows[1].word, 4'h0);
    chk_word(ow, rows[1].word);
    $display("Test mid-run reset done");
    end_sim();
  end
endmodule // eibm_top_tb
`default_nettype wire

// [verilog/eibm_mask_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Word to mask conversion shared with the mask module
interface eibm_mask_if;
  logic [7:0] ctrl;
  logic [63:0] mask;
  modport req (output ctrl, input mask);
  modport gen (input ctrl, output mask);
endinterface : eibm_mask_if
`default_nettype wire

// [verilog/eibm_pkg.sv]
`default_nettype none
package eibm_pkg;
  // Word and block geometry
  localparam int WORD_OCTETS = 8;
  localparam int WORD_DATA_W = 64;
  localparam int WORD_W = 72;
  localparam int BLOCK_W = 128;
  // Vector field widths, then local counter, alignment and LLID sizes
  localparam int CH_W = 8;
  localparam int STATION_W = 48;
  localparam int TIMER_W = 48;
  localparam int COUNTER_W = 24;
  localparam int LOCAL_W = 32;
  localparam int ALIGN_W = 6;
  localparam int LLID_W = 4;
  localparam int LLID_DEPTH = 16;
  // Vector field positions (channel on top, counter at the bottom)
  localparam int VEC_COUNTER_LSB = 0;
  localparam int VEC_TIMER_LSB = 24;
  localparam int VEC_STATION_LSB = 72;
  localparam int VEC_CHANNEL_LSB = 120;
  // Pacing run length
  localparam int PACING_RUN = 33;
  // Mask octet values
  localparam logic [7:0] MASK_DATA = 8'hff;
  localparam logic [7:0] MASK_CTRL = 8'h00;
  // Own station address, arbitrary value
  localparam logic [47:0] OWN_STATION_ADDR = 48'h02_00_00_00_00_01;
  // Word kinds presented with each input word
  typedef enum logic [2:0] {
    EIBM_KIND_PAYLOAD = 3'b000,
    EIBM_KIND_HEADER = 3'b001,
    EIBM_KIND_PACING = 3'b010,
    EIBM_KIND_ENV_IDLE = 3'b011,
    EIBM_KIND_BURST_IDLE = 3'b100
  } eibm_kind_e;
  // Device roles
  typedef enum logic [1:0] {
    EIBM_ROLE_TERM_TX = 2'b00,
    EIBM_ROLE_TERM_RX = 2'b01,
    EIBM_ROLE_UNIT_TX = 2'b10,
    EIBM_ROLE_UNIT_RX = 2'b11
  } eibm_role_e;
endpackage : eibm_pkg
`default_nettype wire

// [verilog/eibm_top.sv]
`timescale 1ns/1ps
`default_nettype none
module eibm_top
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [1:0] i_role,
  input wire logic i_quantum_tick,
  input wire logic i_timer_load,
  input wire logic [47:0] i_timer_load_value,
  input wire logic [47:0] i_rx_offset,
  input wire logic [47:0] i_learned_station,
  input wire logic i_table_wr,
  input wire logic [3:0] i_table_wr_llid,
  input wire logic [47:0] i_table_wr_addr,
  input wire logic i_word_valid,
  input wire logic [2:0] i_word_kind,
  input wire logic [71:0] i_word,
  input wire logic [7:0] i_word_channel,
  input wire logic [3:0] i_header_llid,
  input wire logic [5:0] i_header_align,
  input wire logic i_header_last,
  input wire logic [127:0] i_keystream,
  output logic [127:0] o_vector,
  output logic o_vector_valid,
  output logic o_word_valid,
  output logic [71:0] o_word,
  output logic [31:0] o_local_count,
  output logic [47:0] o_cipher_timer
);
  typedef enum logic [1:0] {
    EIBM_ST_IDLE = 2'b00,
    EIBM_ST_FIRST = 2'b01,
    EIBM_ST_SECOND = 2'b10
  } eibm_state_e;

  eibm_state_e state_reg;
  logic [47:0] timer_reg;
  logic [31:0] local_reg;
  logic [47:0] station_table [0:15];
  logic [127:0] vector_reg;
  logic vector_valid_reg;
  logic out_valid_reg;
  logic [71:0] out_word_reg;
  logic [5:0] pacing_cnt_reg;
  logic [47:0] rx_timer;
  logic [47:0] sel_timer;
  logic [47:0] sel_station;
  logic [63:0] word_mask;
  logic is_payload;
  logic is_header;
  eibm_mask_if mask_bus ();

  // Block keystream counter field packed into the vector
  function automatic logic [127:0] build_vector(input logic [7:0] ch, input logic [47:0] st,
                                                input logic [47:0] tm, input logic [23:0] cn);
    build_vector = {ch, st, tm, cn};
  endfunction

  // Masked keystream XOR on one 64-bit half
  function automatic logic [63:0] apply_half(input logic [63:0] d, input logic [63:0] ks,
                                             input logic [63:0] mk);
    apply_half = d ^ (ks & mk);
  endfunction

  assign mask_bus.ctrl = i_word[71:64];
  eibm_word_mask u_mask
  (
    .m(mask_bus.gen)
  );
  assign word_mask = mask_bus.mask;
  assign is_payload = i_word_valid && (i_word_kind == eibm_pkg::EIBM_KIND_PAYLOAD);
  assign is_header = i_word_valid && (i_word_kind == eibm_pkg::EIBM_KIND_HEADER);

  // Shared 48-bit timer; low 32 bits are the local counter
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      timer_reg <= 48'h0;
    end
    else if (i_timer_load)
    begin
      timer_reg <= i_timer_load_value;
    end
    else if (i_quantum_tick)
    begin
      timer_reg <= timer_reg + 48'h1;
    end
  end

  // Local counter mirrors timer low word
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      local_reg <= 32'h0;
    end
    else if (i_timer_load)
    begin
      local_reg <= i_timer_load_value[31:0];
    end
    else if (i_quantum_tick)
    begin
      local_reg <= local_reg + 32'h1;
    end
  end

  // Receive timer lags by fixed round trip
  assign rx_timer = timer_reg - i_rx_offset;

  // Source selection by role
  always_comb
  begin
    sel_timer = timer_reg;
    sel_station = eibm_pkg::OWN_STATION_ADDR;
    case (i_role)
      eibm_pkg::EIBM_ROLE_TERM_TX:
      begin
        sel_station = eibm_pkg::OWN_STATION_ADDR;
      end
      eibm_pkg::EIBM_ROLE_TERM_RX:
      begin
        sel_station = station_table[i_header_llid];
      end
      eibm_pkg::EIBM_ROLE_UNIT_TX:
      begin
        sel_station = eibm_pkg::OWN_STATION_ADDR;
      end
      eibm_pkg::EIBM_ROLE_UNIT_RX:
      begin
        sel_station = i_learned_station;
        sel_timer = rx_timer;
      end
      default:
      begin
        sel_station = eibm_pkg::OWN_STATION_ADDR;
      end
    endcase
  end

  // Station lookup table, loaded by management
  always_ff @(posedge i_core_clk)
  begin
    if (i_table_wr)
    begin
      station_table[i_table_wr_llid] <= i_table_wr_addr;
    end
  end

  // Vector latched on header; counter field cleared
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      vector_reg <= 128'h0;
      vector_valid_reg <= 1'b0;
    end
    else
    begin
      vector_valid_reg <= 1'b0;
      if (is_header && (sel_timer[5:0] == i_header_align))
      begin
        vector_reg <= build_vector(i_word_channel, sel_station, sel_timer, 24'h0);
        vector_valid_reg <= 1'b1;
      end
      else if (is_header)
      begin
        // Misaligned header still latches so the path never stalls
        vector_reg <= build_vector(i_word_channel, sel_station, sel_timer, 24'h0);
        vector_valid_reg <= 1'b1;
      end
    end
  end

  // Block pairing state; only payload and header words change it, so other bypass words
  // can never shift a block boundary
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_reg <= EIBM_ST_IDLE;
    end
    else if (is_header)
    begin
      state_reg <= i_header_last ? EIBM_ST_IDLE : EIBM_ST_FIRST;
    end
    else if (is_payload)
    begin
      case (state_reg)
        EIBM_ST_FIRST:
        begin
          state_reg <= EIBM_ST_SECOND;
        end
        EIBM_ST_SECOND:
        begin
          state_reg <= EIBM_ST_FIRST;
        end
        default:
        begin
          state_reg <= EIBM_ST_IDLE;
        end
      endcase
    end
  end

  // Pacing run counter, bookkeeping only
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pacing_cnt_reg <= 6'h0;
    end
    else if (i_word_valid && (i_word_kind == eibm_pkg::EIBM_KIND_PACING))
    begin
      pacing_cnt_reg <= (pacing_cnt_reg == 6'(eibm_pkg::PACING_RUN - 1)) ? 6'h0 :
                        pacing_cnt_reg + 6'h1;
    end
  end

  // Output word: payload data octets inside a block ciphered by half, all else passes
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      out_valid_reg <= 1'b0;
      out_word_reg <= 72'h0;
    end
    else
    begin
      out_valid_reg <= i_word_valid;
      if (is_payload && (state_reg == EIBM_ST_FIRST))
      begin
        // Upper half for the first word; unused half dropped on odd tail
        out_word_reg <= {i_word[71:64],
                         apply_half(i_word[63:0], i_keystream[127:64], word_mask)};
      end
      else if (is_payload && (state_reg == EIBM_ST_SECOND))
      begin
        out_word_reg <= {i_word[71:64],
                         apply_half(i_word[63:0], i_keystream[63:0], word_mask)};
      end
      else
      begin
        out_word_reg <= i_word;
      end
    end
  end

  assign o_vector = vector_reg;
  assign o_vector_valid = vector_valid_reg;
  assign o_word_valid = out_valid_reg;
  assign o_word = out_word_reg;
  assign o_local_count = local_reg;
  assign o_cipher_timer = timer_reg;

  a_timer_step: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_quantum_tick && !i_timer_load) |=> (timer_reg == $past(timer_reg) + 48'h1))
    else $error("timer did not advance");
  a_local_match: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    ##1 (local_reg == timer_reg[31:0]))
    else $error("local counter differs");
  a_header_vector: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    is_header |=> (o_vector_valid && o_vector[23:0] == 24'h0))
    else $error("vector not latched");
  a_term_tx_src: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (is_header && i_role == 2'b00) |=> (o_vector[119:72] == eibm_pkg::OWN_STATION_ADDR))
    else $error("terminal tx address wrong");
  a_unit_tx_src: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (is_header && i_role == 2'b10) |=> (o_vector[71:24] == $past(timer_reg)))
    else $error("unit tx timer wrong");
  a_unit_rx_src: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (is_header && i_role == 2'b11) |=> (o_vector[119:72] == $past(i_learned_station)))
    else $error("unit rx address wrong");
  a_header_clear: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_word_valid && !is_payload) |=> (o_word == $past(i_word)))
    else $error("bypass word changed");
  a_ctrl_kept: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    is_payload |=> (o_word[71:64] == $past(i_word[71:64])))
    else $error("flags changed");
  a_pair_toggle: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (is_payload && state_reg == EIBM_ST_FIRST) |=> (state_reg == EIBM_ST_SECOND))
    else $error("pairing lost");
  a_pacing_hold: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_word_valid && !is_payload && !is_header) |=> $stable(state_reg))
    else $error("bypass word moved alignment");
  a_idle_octet: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (is_payload && i_word[71:64] == 8'hff) |=> (o_word == $past(i_word)))
    else $error("idle word ciphered");

  c_header: cover property (@(posedge i_core_clk) is_header ##[1:4] is_payload ##[1:4] is_payload);
  c_odd_tail: cover property (@(posedge i_core_clk) (is_payload && state_reg == EIBM_ST_FIRST)
    ##[1:4] (i_word_valid && i_word_kind == eibm_pkg::EIBM_KIND_ENV_IDLE));
  c_pacing_run: cover property (@(posedge i_core_clk)
    pacing_cnt_reg == 6'(eibm_pkg::PACING_RUN - 1));
  c_pacing_mid: cover property (@(posedge i_core_clk)
    (state_reg == EIBM_ST_SECOND) && i_word_kind == eibm_pkg::EIBM_KIND_PACING);
endmodule // eibm_top
`default_nettype wire

// [verilog/eibm_word_mask.sv]
`timescale 1ns/1ps
`default_nettype none
module eibm_word_mask
(
  eibm_mask_if.gen m
);
  // Control flag set means octet passes clear
  always_comb
  begin
    for (int i = 0; i < eibm_pkg::WORD_OCTETS; i++)
    begin
      m.mask[i*8 +: 8] = m.ctrl[i] ? eibm_pkg::MASK_CTRL : eibm_pkg::MASK_DATA;
    end
  end
endmodule // eibm_word_mask
`default_nettype wire
